// [rtl/apso_frame.sv]
`default_nettype none
// Builds the outgoing word, left-aligned, and its length in bits.
module apso_frame
    import apso_pkg::*;
(
    input  wire logic [31:0] pos_um,
    input  wire logic [2:0]  fmt,
    input  wire logic [2:0]  res,
    input  wire logic        err_flag,
    output logic      [39:0] word,
    output logic      [5:0]  len
);
    logic [25:0] pos;
    logic [25:0] gray;
    logic        par;
    logic [5:0]  crc;
    integer      i;
    logic        fb;

    always_comb begin
        unique case (res)
            3'h0:    pos = 26'((pos_um / 32'd500));
            3'h1:    pos = 26'((pos_um / 32'd100));
            3'h2:    pos = 26'((pos_um / 32'd50));
            3'h3:    pos = 26'((pos_um / 32'd10));
            3'h4:    pos = 26'((pos_um / 32'd5));
            default: pos = pos_um[25:0];
        endcase
        gray = pos ^ (pos >> 1);
        par  = ^pos;
        crc  = 6'h00;
        for (i = 25; i >= 0; i = i - 1) begin
            fb  = crc[5] ^ pos[i];
            crc = {crc[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
        end
        for (i = 1; i >= 0; i = i - 1) begin
            fb  = crc[5] ^ (i == 1 ? ~err_flag : 1'b1);
            crc = {crc[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
        end
        word = 40'h00_0000_0000;
        len  = 6'd26;
        unique case (fmt)
            3'h0: word = {gray, 14'h0000};
            3'h2: begin word = {pos, par, 13'h0000}; len = 6'd27; end
            3'h3: begin word = {pos, ~par, 13'h0000}; len = 6'd27; end
            3'h4: begin word = {pos, err_flag, 13'h0000}; len = 6'd27; end
            3'h5: begin word = {pos, par, err_flag, 12'h000}; len = 6'd28; end
            3'h6: begin word = {pos, ~par, err_flag, 12'h000}; len = 6'd28; end
            3'h7: begin word = {pos, ~err_flag, 1'b1, ~crc, 6'h00}; len = 6'd34; end
            default: word = {pos, 14'h0000};
        endcase
    end
endmodule : apso_frame
`default_nettype wire

// [rtl/apso_pkg.sv]
`default_nettype none
package apso_pkg;
    // Core clock and timing.
    localparam int  CLK_MHZ              = 125;
    localparam int  TRANSFER_TIMEOUT_NS  = 25000;
    localparam int  FIRST_DATA_DELAY_NS  = 7000;
    localparam int  TIMEOUT_CYCLES       = (TRANSFER_TIMEOUT_NS * CLK_MHZ) / 1000;
    localparam int  DELAY_CYCLES         = (FIRST_DATA_DELAY_NS * CLK_MHZ) / 1000;
    // Gap of idle link clock that closes a transfer, well under the longest allowed.
    localparam int  IDLE_GAP_NS          = 20000;
    localparam int  IDLE_GAP_CYCLES      = (IDLE_GAP_NS * CLK_MHZ) / 1000;
    localparam int  ACK_PERIODS          = 3;
    localparam int  POS_BITS             = 26;
    localparam int  STAT_BITS            = 2;
    localparam int  CRC_BITS             = 6;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_POSITION  = 8'h04;
    localparam logic [7:0] REG_STATUS    = 8'h08;
    localparam logic [7:0] REG_IRQ       = 8'h0C;
    localparam logic [7:0] REG_MASK      = 8'h10;
    localparam logic [7:0] REG_COUNT     = 8'h14;

    // Control field positions and reset value.
    localparam int  CTRL_FMT_LSB         = 0;
    localparam int  CTRL_RES_LSB         = 4;
    localparam int  CTRL_ERR_FLAG        = 8;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;

    // Interrupt bits.
    localparam int  IRQ_START            = 0;
    localparam int  IRQ_DONE             = 1;
    localparam int  IRQ_TIMEOUT          = 2;

    typedef enum logic [2:0] {
        cfg_programmable,
        cfg_plain_binary,
        cfg_even_parity,
        cfg_odd_parity,
        cfg_error_bit,
        cfg_even_parity_error,
        cfg_odd_parity_error,
        cfg_bidi_frame_binary
    } apso_fmt_t;

    typedef enum logic [2:0] {
        RES_500UM,
        RES_100UM,
        RES_50UM,
        RES_10UM,
        RES_5UM,
        RES_1UM
    } apso_res_t;
endpackage : apso_pkg
`default_nettype wire

// [rtl/apso_serial_out.sv]
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Device is idle and ready within 25 us after the last clock edge.
// - Synchronous serial data delay stays at or below 7 us.
// - Frame variant holds acknowledge for three clock periods before the start.
// - Position LSB weight follows configured resolution, 500 down to 1 um.
// - A configuration sends the position word Gray coded.
// - Even parity configuration appends a bit making the ones count even.
// - Odd parity configuration appends a bit making the ones count odd.
// - Error configuration appends an error indication bit.
// - Combined configurations append parity then the error bit.
//////////////////////////////////////////////////////////////////////////////
module apso_serial_out
    import apso_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        line_clock_pair,
    output logic             data_out,
    output logic             irq
);
    //////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACK,
        ST_START,
        ST_SHIFT,
        ST_TAIL,
        ST_RECOVER
    } apso_state_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] ctrl;
        logic [31:0] position;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic [15:0] count;
        logic        clk_s1;
        logic        clk_s2;
        logic        clk_s3;
        apso_state_t state;
        logic [39:0] shreg;
        logic [5:0]  left;
        logic [1:0]  acks;
        logic [15:0] idle;
        logic        data;
        logic        irq;
    } apso_regs_t;

    apso_regs_t  r;
    apso_regs_t  next_r;
    logic [39:0] frame_word;
    logic [5:0]  frame_len;
    logic        fall;
    logic        rise;
    logic        bidi;
    logic [31:0] merged;
    integer      b;

    apso_frame u_frame (
        .pos_um   (r.position),
        .fmt      (r.ctrl[CTRL_FMT_LSB +: 3]),
        .res      (r.ctrl[CTRL_RES_LSB +: 3]),
        .err_flag (r.ctrl[CTRL_ERR_FLAG]),
        .word     (frame_word),
        .len      (frame_len)
    );

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        fall   = r.clk_s3 & ~r.clk_s2;
        rise   = ~r.clk_s3 & r.clk_s2;
        bidi   = (r.ctrl[CTRL_FMT_LSB +: 3] == 3'h7);
        merged = r.w_data;

        // Edges are detected from the second and third stages of the synchroniser.
        next_r.clk_s1 = line_clock_pair;
        next_r.clk_s2 = r.clk_s1;
        next_r.clk_s3 = r.clk_s2;

        // Write address and data are taken in either order.
        if (s_axi_awvalid && r.awready) begin
            next_r.aw_addr = s_axi_awaddr[7:0];
            next_r.aw_got  = 1'b1;
            next_r.awready = 1'b0;
        end
        if (s_axi_wvalid && r.wready) begin
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
            next_r.w_got  = 1'b1;
            next_r.wready = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            next_r.bvalid = 1'b1;
            next_r.bresp  = 2'b00;
            for (b = 0; b < 4; b = b + 1) begin
                if (!r.w_strb[b]) begin
                    merged[b*8 +: 8] = 8'h00;
                end
            end
            unique case (r.aw_addr)
                REG_CTRL: begin
                    for (b = 0; b < 4; b = b + 1) begin
                        if (r.w_strb[b]) begin
                            next_r.ctrl[b*8 +: 8] = r.w_data[b*8 +: 8];
                        end
                    end
                end
                REG_POSITION: begin
                    for (b = 0; b < 4; b = b + 1) begin
                        if (r.w_strb[b]) begin
                            next_r.position[b*8 +: 8] = r.w_data[b*8 +: 8];
                        end
                    end
                end
                REG_IRQ:  next_r.status = r.status & ~merged[2:0];
                REG_MASK: next_r.mask = merged[2:0];
                REG_STATUS, REG_COUNT: ;
                default:  next_r.bresp = 2'b10;
            endcase
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid  = 1'b0;
            next_r.aw_got  = 1'b0;
            next_r.w_got   = 1'b0;
            next_r.awready = 1'b1;
            next_r.wready  = 1'b1;
        end

        // Reads answer one cycle after the address is taken.
        if (s_axi_arvalid && r.arready) begin
            next_r.arready = 1'b0;
            next_r.rvalid  = 1'b1;
            next_r.rresp   = 2'b00;
            unique case (s_axi_araddr[7:0])
                REG_CTRL:     next_r.rdata = r.ctrl;
                REG_POSITION: next_r.rdata = r.position;
                REG_STATUS:   next_r.rdata = {29'h0000000, r.state == ST_IDLE, bidi, r.data};
                REG_IRQ:      next_r.rdata = {29'h0000000, r.status};
                REG_MASK:     next_r.rdata = {29'h0000000, r.mask};
                REG_COUNT:    next_r.rdata = {16'h0000, r.count};
                default: begin
                    next_r.rdata = 32'h0000_0000;
                    next_r.rresp = 2'b10;
                end
            endcase
        end
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid  = 1'b0;
            next_r.arready = 1'b1;
        end

        // Idle counter restarts on every link clock edge.
        if (fall || rise) begin
            next_r.idle = 16'h0000;
        end else if (r.idle != 16'hFFFF) begin
            next_r.idle = r.idle + 16'h0001;
        end

        unique case (r.state)
            ST_IDLE: begin
                next_r.data = 1'b1;
                if (fall) begin
                    next_r.shreg = frame_word;
                    next_r.left  = frame_len;
                    next_r.acks  = 2'd0;
                    next_r.count = r.count + 16'h0001;
                    next_r.status[IRQ_START] = 1'b1;
                    next_r.state = bidi ? ST_ACK : ST_SHIFT;
                end
            end
            ST_ACK: begin
                next_r.data = 1'b0;
                if (rise) begin
                    // The start bit waits for the rise that closes the third full period.
                    if (r.acks == 2'(ACK_PERIODS)) begin
                        next_r.state = ST_START;
                        next_r.data  = 1'b1;
                    end else begin
                        next_r.acks = r.acks + 2'd1;
                    end
                end
            end
            ST_START: begin
                if (rise) begin
                    next_r.state = ST_SHIFT;
                    next_r.data  = 1'b0;
                end
            end
            ST_SHIFT: begin
                if (rise) begin
                    if (r.left == 6'd0) begin
                        next_r.data  = 1'b0;
                        next_r.state = ST_TAIL;
                        next_r.status[IRQ_DONE] = 1'b1;
                    end else begin
                        next_r.data  = r.shreg[39];
                        next_r.shreg = {r.shreg[38:0], 1'b0};
                        next_r.left  = r.left - 6'd1;
                    end
                end
            end
            ST_TAIL: begin
                // Line stays low until the link clock has been idle for IDLE_GAP_CYCLES.
                next_r.data = 1'b0;
                if (r.idle == 16'(IDLE_GAP_CYCLES)) begin
                    next_r.state = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                next_r.data  = 1'b1;
                next_r.state = ST_IDLE;
            end
            default: next_r.state = ST_IDLE;
        endcase

        if (r.state != ST_IDLE && r.state != ST_RECOVER && r.state != ST_TAIL
            && r.idle == 16'(IDLE_GAP_CYCLES)) begin
            next_r.state = ST_RECOVER;
            next_r.status[IRQ_TIMEOUT] = 1'b1;
        end

        // A new event beats a clear written in the same cycle.
        next_r.irq = |(next_r.status & r.mask);
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r          <= '0;
            r.awready  <= 1'b1;
            r.wready   <= 1'b1;
            r.arready  <= 1'b1;
            r.ctrl     <= CTRL_RESET;
            r.clk_s1   <= 1'b1;
            r.clk_s2   <= 1'b1;
            r.clk_s3   <= 1'b1;
            r.state    <= ST_IDLE;
            r.data     <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_arready = r.arready;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign s_axi_rvalid  = r.rvalid;
    assign data_out      = r.data;
    assign irq           = r.irq;
endmodule : apso_serial_out
`default_nettype wire

// [testbench/apso_master_model.sv]
`default_nettype none
module apso_master_model (
    output logic        line_clock_pair,
    input  wire logic   data_out,
    output logic [63:0] rx_word
);
    timeunit 1ns;
    timeprecision 100ps;
    initial line_clock_pair = 1'h1;
    // Edges sit 4 ns after the rising core clock edge (1 ns from axi plus 3 ns here) so the sampler never races them.
    task automatic read(input int nbits);
        rx_word = 64'h0;
        #3;
        line_clock_pair = 1'h0;
        #80;
        for (int i = 0; i < nbits; i++) begin
            line_clock_pair = 1'h1;
            #80;
            rx_word = {rx_word[62:0], data_out};
            line_clock_pair = 1'h0;
            #80;
        end
        line_clock_pair = 1'h1;
        #25100;
    endtask : read
endmodule : apso_master_model
`default_nettype wire

// [testbench/apso_serial_out_properties.sv]
`default_nettype none
module apso_serial_out_properties
    import apso_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        line_clock_pair,
    input wire logic        data_out,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 100ps;
    int   idle_cnt;
    int   since_edge;
    int   wr_age;
    logic clk_q;
    // Counted on the raw line clock, so the margins below cover the sampler delay.
    always_ff @(posedge aclk) begin
        clk_q <= line_clock_pair;
        if (!aresetn || !line_clock_pair) idle_cnt <= 0;
        else if (idle_cnt < TIMEOUT_CYCLES) idle_cnt <= idle_cnt + 1;
        if (!aresetn || clk_q != line_clock_pair) since_edge <= 0;
        else if (since_edge < 1000) since_edge <= since_edge + 1;
        if (!aresetn || (s_axi_wvalid && s_axi_wready)) wr_age <= 0;
        else if (wr_age < 15) wr_age <= wr_age + 1;
    end
    //////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_pair;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_IDLE_HIGH: assert property (idle_cnt > IDLE_GAP_CYCLES + 8 |-> data_out)
        else $error("data line low on idle clock");
    AST_BIT_TIMING: assert property ($changed(data_out) && idle_cnt < IDLE_GAP_CYCLES - 8 |-> since_edge <= 8)
        else $error("data change not tied to a clock edge");
    AST_RESET_IDLE: assert property ($rose(aresetn) |-> data_out && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
    AST_IRQ_CLEAR: assert property ($fell(irq) |-> wr_age <= 4)
        else $error("interrupt dropped without a write");
    AST_WR_RESP: assert property (wr_pair |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready while response pending");
    AST_WR_BACK: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
        else $error("write channels not ready after response");
    AST_RD_RESP: assert property (rd_take |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
endmodule : apso_serial_out_properties
bind apso_serial_out apso_serial_out_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .line_clock_pair, .data_out, .irq);
`default_nettype wire

// [testbench/apso_serial_out_tb.sv]
`default_nettype none
module apso_serial_out_tb;
    import apso_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] POS_UM = 32'h0012_D644;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, line_clock_pair, data_out, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [63:0] rx_word;
    int          failures, num_checks;
    int          res_um [6] = '{500, 100, 50, 10, 5, 1};
    apso_serial_out u_apso_serial_out (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_clock_pair, .data_out, .irq);
    apso_master_model u_master (.line_clock_pair, .data_out, .rx_word);
    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    // One bus cycle; returns 1 ns after the response so registered outputs have settled.
    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 1'h0;
        @(posedge aclk);
        if (wr) begin
            awaddr <= {24'h0, a};
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
        end else begin
            araddr <= {24'h0, a};
            arvalid <= 1'h1;
            rready <= 1'h1;
        end
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (arready) arvalid <= 1'h0;
            if (bvalid && bready) begin
                rsp = bresp;
                bready <= 1'h0;
                done = 1'h1;
            end
            if (rvalid && rready) begin
                rsp = rresp;
                rd = rdata;
                rready <= 1'h0;
                done = 1'h1;
            end
        end
        #1;
        check("bus answer", 64'h1, 64'(done));
        if (!done) summarize();
    endtask : axi
    //////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        axi(0, REG_CTRL, 32'h0);
        check("ctrl reset", 64'(CTRL_RESET), 64'(rd));
        axi(0, 8'h40, 32'h0);
        check("unmapped resp", 64'h2, 64'(rsp));
        axi(1, 8'h40, 32'h0);
        check("unmapped write resp", 64'h2, 64'(rsp));
        axi(1, REG_POSITION, POS_UM);
        check("write resp", 64'h0, 64'(rsp));
        axi(0, REG_POSITION, 32'h0);
        check("position", 64'(POS_UM), 64'(rd));
    endtask : t_regs
    task automatic t_serial();
        logic [25:0] v;
        logic [63:0] e;
        int          len;
        for (int f = 0; f < 7; f++) begin
            axi(1, REG_CTRL, 32'(f) | (32'(f % 6) << CTRL_RES_LSB) | (32'(f[0]) << CTRL_ERR_FLAG));
            v = 26'(POS_UM / res_um[f % 6]);
            e = (f == 0) ? {38'h0, v ^ (v >> 1)} : {38'h0, v};
            len = 26;
            if (f == 2 || f == 5) e = {e[62:0], ^v};
            if (f == 3 || f == 6) e = {e[62:0], ~^v};
            if (f >= 4) e = {e[62:0], 1'(f[0])};
            len = len + int'(f >= 2) + int'(f >= 5);
            u_master.read(len);
            check("serial word", e, rx_word);
            check("line idle", 64'h1, 64'(data_out));
            axi(0, REG_STATUS, 32'h0);
            check("ready again", 64'h1, 64'(rd[2]));
        end
        axi(0, REG_COUNT, 32'h0);
        check("read count", 64'h7, 64'(rd[15:0]));
    endtask : t_serial
    task automatic t_frame();
        axi(1, REG_CTRL, 32'h0000_0057);
        u_master.read(39);
        check("ack and start", 64'h2, 64'(rx_word[38:34]));
        check("frame position", 64'(POS_UM), 64'(rx_word[33:8]));
        check("frame status", 64'h3, 64'(rx_word[7:6]));
        axi(0, REG_STATUS, 32'h0);
        check("status idle frame high", 64'h7, 64'(rd[2:0]));
    endtask : t_frame
    task automatic t_irq();
        axi(1, REG_IRQ, 32'h7);
        axi(1, REG_MASK, 32'h4);
        check("irq quiet", 64'h0, 64'(irq));
        u_master.read(10);
        check("abort rests high", 64'h1, 64'(data_out));
        check("irq timeout", 64'h1, 64'(irq));
        axi(0, REG_IRQ, 32'h0);
        check("timeout flag", 64'h1, 64'(rd[IRQ_TIMEOUT]));
        check("start without done", 64'h1, 64'(rd[IRQ_DONE:IRQ_START]));
        axi(1, REG_MASK, 32'h0);
        check("irq masked", 64'h0, 64'(irq));
        axi(1, REG_MASK, 32'h4);
        check("irq unmasked", 64'h1, 64'(irq));
        axi(1, REG_IRQ, 32'h4);
        check("irq cleared", 64'h0, 64'(irq));
    endtask : t_irq
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        num_checks = 0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hF;
        aresetn = 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_serial();
        t_frame();
        t_irq();
        summarize();
    end
endmodule : apso_serial_out_tb
`default_nettype wire
